// File: hdl/nvc_command_regs.svh
// Purpose: Offsets, field positions and reset values of the command block
// Assumes: Offsets are word indices; byte address is four times the index
// Notes:   Definitions only
`ifndef NVC_COMMAND_REGS_SVH
`define NVC_COMMAND_REGS_SVH

// ----------------------------------------------------------------------
// Register indices
// ----------------------------------------------------------------------
`define NVC_IDX_CTRL    16'h400a
`define NVC_IDX_STAT    16'h4012
`define NVC_IDX_MASK    16'h401a
`define NVC_IDX_KEY     16'h4008

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define NVC_B_PROG      15
`define NVC_B_MEM       13
`define NVC_B_FINAL     11
`define NVC_B_VERIFY    10
`define NVC_B_WRITE     9
`define NVC_B_READ      8
`define NVC_B_MARG_HI   7
`define NVC_B_MARG_LO   6
`define NVC_B_BULK      5
`define NVC_B_PAGE_HI   1
`define NVC_B_PAGE_LO   0
`define NVC_B_DONE      5
`define NVC_B_FAIL      4
`define NVC_B_UNLOCKED  0

// ----------------------------------------------------------------------
// Reset values and codes
// ----------------------------------------------------------------------
`define NVC_RST_MEM     1'b1
`define NVC_RST_MARGIN  2'h0
`define NVC_RST_BULK    1'b0
`define NVC_RST_PAGE    2'h0
`define NVC_RST_MASK    1'b1
`define NVC_MARGIN_RSVD 2'h1
`define NVC_PAGE_RSVD   2'h3
`define NVC_EXT_BASE    3'h2
`define NVC_UNLOCK_CODE 16'h5a3c

`endif

// File: hdl/nvc_pkg.sv
// Purpose: Types shared by the command block and its neighbours
// Assumes: One memory engine behind the block
// Notes:   Field layout lives in nvc_command_regs.svh
package nvc_pkg;

    typedef enum logic [1:0]
    {
        NVC_OP_READ,
        NVC_OP_WRITE,
        NVC_OP_VERIFY,
        NVC_OP_FINAL
    } nvc_op_type;

    typedef struct packed
    {
        nvc_op_type op;
        logic       toOtp;
        logic       bulk;
        logic [2:0] page;
        logic [1:0] margin;
    } nvc_cmd_type;

    typedef struct packed
    {
        logic done;
        logic readFail;
        logic verifyFail;
        logic autoProgDone;
    } nvc_result_type;

endpackage

// File: hdl/nvc_command_control.sv
// Purpose: Command control, event flags and interrupt of the NV memory
// Assumes: Classic Wishbone slave, 32-bit data, inputs synchronous
// Notes:   One memory operation at a time; engine answers with done
`timescale 1ns/1ps
`include "nvc_command_regs.svh"

// Summary of operation
// - Writing one to bit 15 enters programming
// - Programming state holds until device reset
// - Bit 13 picks OTP (one) or EEPROM
// - Bit 11 issues finalise command
// - Bit 10 issues verify command
// - Bit 9 issues write command
// - Bit 8 issues read command
// - Bits 7:6 select read margin level
// - Bit 5 selects single page or all
// - OTP page codes map to pages 0-3
// - EEPROM page codes map to 2-4, 11 reserved
// - Protected fields ignore writes until unlocked
// - Done flag set at command or autoprogram end
// - Fail flag on read, verify, refused command
// - Flags set on rising edge, write-one clears
// - Unmasked set flag raises memory interrupt
// - Mask bits 5,4 gate flags, reset masked
module nvc_command_control
#(
    parameter logic [15:0] UNLOCK_CODE = `NVC_UNLOCK_CODE // arbitrary value
)
(
    // Clock and reset
    input  wire logic                  sys_clk,
    input  wire logic                  reset_n,
    // Wishbone slave
    input  wire logic                  wb_cyc_i,
    input  wire logic                  wb_stb_i,
    input  wire logic                  wb_we_i,
    input  wire logic [17:0]           wb_adr_i,
    input  wire logic [3:0]            wb_sel_i,
    input  wire logic [31:0]           wb_dat_i,
    output      logic [31:0]           wb_dat_o,
    output      logic                  wb_ack_o,
    // Memory engine
    output      nvc_pkg::nvc_cmd_type    memCmd,
    output      logic                  memStart,
    input  wire nvc_pkg::nvc_result_type memResult,
    // Device status
    output      logic                  progState,
    output      logic                  memIrq
);
    import nvc_pkg::*;

    typedef enum {NVC_IDLE, NVC_BUSY} nvc_state_type;

    // ------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------
    logic        ackReg;
    logic [31:0] rdataReg;
    wire         busReq    = wb_cyc_i & wb_stb_i & ~ackReg;
    wire         busWr     = busReq & wb_we_i;
    wire  [15:0] wordIdx   = wb_adr_i[17:2];
    wire         selCtrl   = wordIdx == `NVC_IDX_CTRL;
    wire         selStat   = wordIdx == `NVC_IDX_STAT;
    wire         selMask   = wordIdx == `NVC_IDX_MASK;
    wire         selKey    = wordIdx == `NVC_IDX_KEY;
    wire         wrHi      = wb_sel_i[1];
    wire         wrLo      = wb_sel_i[0];
    wire         ctrlWrHi  = busWr & selCtrl & wrHi;
    wire         ctrlWrLo  = busWr & selCtrl & wrLo;
    wire         statWrLo  = busWr & selStat & wrLo;
    wire         maskWrLo  = busWr & selMask & wrLo;
    wire         keyWr     = busWr & selKey & wrHi & wrLo;

    // ------------------------------------------------------------------
    // Control fields
    // ------------------------------------------------------------------
    logic        unlocked_reg;
    logic        progState_reg;
    logic        memSel_reg;
    logic [1:0]  margin_reg;
    logic        bulk_reg;
    logic [1:0]  page_reg;
    logic        memSel_next;
    logic [1:0]  margin_next;
    logic        bulk_next;
    logic [1:0]  page_next;
    nvc_state_type state_reg;
    logic        finalised_reg;

    // Protected fields only move when the key is open
    wire protHi = ctrlWrHi & unlocked_reg;
    wire protLo = ctrlWrLo & unlocked_reg;
    assign memSel_next = protHi ? wb_dat_i[`NVC_B_MEM] : memSel_reg;
    assign margin_next = protLo ?
        wb_dat_i[`NVC_B_MARG_HI:`NVC_B_MARG_LO] : margin_reg;
    assign bulk_next   = ctrlWrLo ? wb_dat_i[`NVC_B_BULK] : bulk_reg;
    assign page_next   = ctrlWrLo ?
        wb_dat_i[`NVC_B_PAGE_HI:`NVC_B_PAGE_LO] : page_reg;

    // ------------------------------------------------------------------
    // Command issue
    // ------------------------------------------------------------------
    wire  cmdFinal  = protHi & wb_dat_i[`NVC_B_FINAL];
    wire  cmdVerify = protHi & wb_dat_i[`NVC_B_VERIFY];
    wire  cmdWrite  = protHi & wb_dat_i[`NVC_B_WRITE];
    wire  cmdRead   = protHi & wb_dat_i[`NVC_B_READ];
    wire  cmdAny    = cmdFinal | cmdVerify | cmdWrite | cmdRead;
    // Commands outside programming or while busy are dropped
    wire  cmdTake   = cmdAny & progState_reg & (state_reg == NVC_IDLE);
    nvc_op_type cmdOp;
    assign cmdOp = cmdFinal  ? NVC_OP_FINAL :
                   cmdVerify ? NVC_OP_VERIFY :
                   cmdWrite  ? NVC_OP_WRITE : NVC_OP_READ;
    // EEPROM supports reads only; every OTP write fails once a finalise has completed with no verify fail rising in its done cycle
    wire  extBad    = ~memSel_next &
                      ((cmdOp != NVC_OP_READ) ||
                       (~bulk_next && page_next == `NVC_PAGE_RSVD));
    wire  finalBad  = memSel_next & (cmdOp == NVC_OP_WRITE) &
                      finalised_reg;
    wire  marginBad = memSel_next & (margin_next == `NVC_MARGIN_RSVD) &
                      (cmdOp == NVC_OP_READ || cmdOp == NVC_OP_VERIFY);
    wire  cmdReject = cmdTake & (extBad | finalBad | marginBad);
    wire  cmdGo     = cmdTake & ~cmdReject;
    wire  [2:0] physPage = memSel_next ? {1'b0, page_next}
                         : `NVC_EXT_BASE + {1'b0, page_next};
    nvc_cmd_type cmdNext;
    assign cmdNext = '{op: cmdOp, toOtp: memSel_next, bulk: bulk_next,
                       page: physPage, margin: margin_next};

    // ------------------------------------------------------------------
    // Event edges and flags
    // ------------------------------------------------------------------
    nvc_result_type resPrev_reg;
    logic        rejectPulse_reg;
    logic        flagDone_reg;
    logic        flagFail_reg;
    logic        maskDone_reg;
    logic        maskFail_reg;
    wire  doneRise  = memResult.done & ~resPrev_reg.done;
    wire  autoRise  = memResult.autoProgDone & ~resPrev_reg.autoProgDone;
    wire  rdRise    = memResult.readFail & ~resPrev_reg.readFail;
    wire  vfRise    = memResult.verifyFail & ~resPrev_reg.verifyFail;
    wire  opDone    = doneRise & (state_reg == NVC_BUSY);
    wire  doneEvent = opDone | autoRise | rejectPulse_reg;
    wire  failEvent = rdRise | vfRise | rejectPulse_reg;
    wire  clrDone   = statWrLo & wb_dat_i[`NVC_B_DONE];
    wire  clrFail   = statWrLo & wb_dat_i[`NVC_B_FAIL];
    // Set beats a clear landing in the same cycle
    wire  flagDone_next = doneEvent | (flagDone_reg & ~clrDone);
    wire  flagFail_next = failEvent | (flagFail_reg & ~clrFail);

    // ------------------------------------------------------------------
    // Sequential state
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
        begin
            unlocked_reg  <= 1'b0;
            progState_reg <= 1'b0;
            memSel_reg    <= `NVC_RST_MEM;
            margin_reg    <= `NVC_RST_MARGIN;
            bulk_reg      <= `NVC_RST_BULK;
            page_reg      <= `NVC_RST_PAGE;
        end
        else
        begin
            if (keyWr)
                unlocked_reg <= wb_dat_i[15:0] == UNLOCK_CODE;
            // Zero writes never leave; only reset does
            if (protHi && wb_dat_i[`NVC_B_PROG])
                progState_reg <= 1'b1;
            memSel_reg <= memSel_next;
            margin_reg <= margin_next;
            bulk_reg   <= bulk_next;
            page_reg   <= page_next;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
        begin
            state_reg       <= NVC_IDLE;
            memStart        <= 1'b0;
            memCmd          <= '0;
            rejectPulse_reg <= 1'b0;
            finalised_reg   <= 1'b0;
        end
        else
        begin
            memStart        <= cmdGo;
            rejectPulse_reg <= cmdReject;
            if (cmdGo)
                memCmd <= cmdNext;
            unique case (state_reg)
                NVC_IDLE:
                    if (cmdGo)
                        state_reg <= NVC_BUSY;
                NVC_BUSY:
                    if (opDone)
                        state_reg <= NVC_IDLE;
            endcase
            if (opDone && memCmd.op == NVC_OP_FINAL && !vfRise)
                finalised_reg <= 1'b1;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
        begin
            resPrev_reg  <= '0;
            flagDone_reg <= 1'b0;
            flagFail_reg <= 1'b0;
            maskDone_reg <= `NVC_RST_MASK;
            maskFail_reg <= `NVC_RST_MASK;
        end
        else
        begin
            resPrev_reg  <= memResult;
            flagDone_reg <= flagDone_next;
            flagFail_reg <= flagFail_next;
            if (maskWrLo)
            begin
                maskDone_reg <= wb_dat_i[`NVC_B_DONE];
                maskFail_reg <= wb_dat_i[`NVC_B_FAIL];
            end
        end
    end

    // ------------------------------------------------------------------
    // Read data and acknowledge
    // ------------------------------------------------------------------
    logic [31:0] rdataNext;
    always_comb
    begin
        rdataNext = 32'h0000_0000;
        if (selCtrl)
        begin
            rdataNext[`NVC_B_PROG]  = progState_reg;
            rdataNext[`NVC_B_MEM]   = memSel_reg;
            rdataNext[`NVC_B_MARG_HI:`NVC_B_MARG_LO] = margin_reg;
            rdataNext[`NVC_B_BULK]  = bulk_reg;
            rdataNext[`NVC_B_PAGE_HI:`NVC_B_PAGE_LO] = page_reg;
        end
        else if (selStat)
        begin
            rdataNext[`NVC_B_DONE] = flagDone_reg;
            rdataNext[`NVC_B_FAIL] = flagFail_reg;
        end
        else if (selMask)
        begin
            rdataNext[`NVC_B_DONE] = maskDone_reg;
            rdataNext[`NVC_B_FAIL] = maskFail_reg;
        end
        else if (selKey)
            rdataNext[`NVC_B_UNLOCKED] = unlocked_reg;
    end

    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
        begin
            ackReg   <= 1'b0;
            rdataReg <= 32'h0000_0000;
        end
        else
        begin
            ackReg   <= busReq;
            rdataReg <= (busReq && !wb_we_i) ? rdataNext : 32'h0000_0000;
        end
    end

    assign wb_ack_o  = ackReg;
    assign wb_dat_o  = rdataReg;
    assign progState = progState_reg;
    assign memIrq    = (flagDone_reg & ~maskDone_reg) |
                       (flagFail_reg & ~maskFail_reg);

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);

    property p_prog_enter;
        protHi && wb_dat_i[`NVC_B_PROG] |=> progState;
    endproperty
    a_prog_enter: assert property (p_prog_enter)
        else $error("programming state not entered");

    property p_prog_sticky;
        progState |=> progState [*8];
    endproperty
    a_prog_sticky: assert property (p_prog_sticky)
        else $error("programming state left");

    property p_target;
        memStart |-> memCmd.toOtp == memSel_reg;
    endproperty
    a_target: assert property (p_target)
        else $error("command target differs from select bit");

    property p_margin;
        memStart |-> memCmd.margin == margin_reg && memCmd.bulk == bulk_reg;
    endproperty
    a_margin: assert property (p_margin)
        else $error("margin or scope not carried to command");

    property p_otp_page;
        memStart && memCmd.toOtp |-> memCmd.page == {1'b0, page_reg};
    endproperty
    a_otp_page: assert property (p_otp_page)
        else $error("OTP page mapping wrong");

    property p_ext_page;
        memStart && !memCmd.toOtp |-> memCmd.page == page_reg + 3'h2;
    endproperty
    a_ext_page: assert property (p_ext_page)
        else $error("EEPROM page mapping wrong");

    property p_locked;
        !unlocked_reg && ctrlWrHi |=> $stable(memSel_reg) && !memStart;
    endproperty
    a_locked: assert property (p_locked)
        else $error("protected field changed while locked");

    property p_done_flag;
        doneEvent |=> flagDone_reg;
    endproperty
    a_done_flag: assert property (p_done_flag)
        else $error("done flag not set");

    property p_fail_flag;
        failEvent |=> flagFail_reg;
    endproperty
    a_fail_flag: assert property (p_fail_flag)
        else $error("fail flag not set");

    property p_flag_hold;
        flagFail_reg && !clrFail |=> flagFail_reg;
    endproperty
    a_flag_hold: assert property (p_flag_hold)
        else $error("fail flag dropped without clear");

    property p_irq;
        flagDone_reg && !maskDone_reg |-> memIrq;
    endproperty
    a_irq: assert property (p_irq)
        else $error("interrupt missing for unmasked flag");

    property p_mask;
        maskDone_reg && maskFail_reg |-> !memIrq;
    endproperty
    a_mask: assert property (p_mask)
        else $error("masked flags raised interrupt");

    property p_one_start;
        memStart |=> !memStart until_with opDone;
    endproperty
    a_one_start: assert property (p_one_start)
        else $error("second start before completion");

    c_start: cover property (memStart);
    c_done:  cover property (memStart ##[1:50] flagDone_reg);
    c_fail:  cover property (rejectPulse_reg ##1 flagFail_reg);
    c_irq:   cover property (!memIrq ##1 memIrq);
endmodule

// File: testbench/nvc_command_control_tb.sv
// Purpose: Self-checking bench for the NV memory command block
// Assumes: Single-cycle Wishbone slave, engine modelled by bench pulses
// Notes:   Engine results are driven by hand, one event at a time
`timescale 1ns/1ps
`include "nvc_command_regs.svh"

module nvc_command_control_tb;
    import nvc_pkg::*;

    // ------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------
    logic           sys_clk;
    logic           reset_n;
    logic           wbCyc;
    logic           wbStb;
    logic           wbWe;
    logic [17:0]    wbAdr;
    logic [3:0]     wbSel;
    logic [31:0]    wbDatI;
    logic [31:0]    wbDatO;
    logic           wbAck;
    nvc_cmd_type    memCmd;
    logic           memStart;
    nvc_result_type memResult;
    logic           progState;
    logic           memIrq;
    int             bad_count;
    int             check_count;
    int             startCount = 0;
    nvc_cmd_type    lastCmd = '0;
    logic [15:0]    rd;

    nvc_command_control u_nvc_command_control (
        .sys_clk   (sys_clk),
        .reset_n   (reset_n),
        .wb_cyc_i  (wbCyc),
        .wb_stb_i  (wbStb),
        .wb_we_i   (wbWe),
        .wb_adr_i  (wbAdr),
        .wb_sel_i  (wbSel),
        .wb_dat_i  (wbDatI),
        .wb_dat_o  (wbDatO),
        .wb_ack_o  (wbAck),
        .memCmd    (memCmd),
        .memStart  (memStart),
        .memResult (memResult),
        .progState (progState),
        .memIrq    (memIrq)
    );

    initial
    begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    // Start pulses last one cycle, so count them at every edge
    always @(posedge sys_clk)
    begin
        if (memStart === 1'b1)
        begin
            startCount <= startCount + 1;
            lastCmd    <= memCmd;
        end
    end

    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic summarize();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                         input string what);
        check_count++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("BAD %0t %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    // Holds the whole request until ack is sampled high
    task automatic busOp(input logic we, input logic [15:0] idx,
                         input logic [15:0] wdat, output logic [15:0] rdat);
        int n;
        n = 0;
        @(posedge sys_clk);
        wbCyc  <= 1'b1;
        wbStb  <= 1'b1;
        wbWe   <= we;
        wbSel  <= 4'hf;
        wbAdr  <= {idx, 2'b00};
        wbDatI <= {16'h0000, wdat};
        do
        begin
            @(posedge sys_clk);
            n++;
        end
        while (wbAck !== 1'b1 && n < 50);
        rdat = wbDatO[15:0];
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
        if (n >= 50)
        begin
            bad_count++;
            summarize();
        end
    endtask

    task automatic wr(input logic [15:0] idx, input logic [15:0] d);
        logic [15:0] dummy;
        busOp(1'b1, idx, d, dummy);
    endtask

    task automatic rdChk(input logic [15:0] idx, input logic [15:0] exp);
        busOp(1'b0, idx, 16'h0000, rd);
        check({16'h0000, rd}, {16'h0000, exp}, "read");
    endtask

    task automatic pulse(input nvc_result_type v);
        @(posedge sys_clk);
        memResult <= v;
        @(posedge sys_clk);
        memResult <= '0;
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge sys_clk);
    endtask

    function automatic nvc_cmd_type mk(nvc_op_type op, logic o, logic b,
                                       logic [2:0] p, logic [1:0] m);
        mk = '{op: op, toOtp: o, bulk: b, page: p, margin: m};
    endfunction

    // Issue, check launch, finish, check and clear the done flag
    task automatic runCmd(input logic [15:0] ctrl, input nvc_cmd_type exp);
        int n0;
        n0 = startCount;
        wr(`NVC_IDX_CTRL, ctrl);
        idle(2);
        check(startCount, n0 + 1, "one start");
        check({23'h0, lastCmd}, {23'h0, exp}, "command");
        pulse('{done: 1'b1, default: 1'b0});
        rdChk(`NVC_IDX_STAT, 16'h0020);
        wr(`NVC_IDX_STAT, 16'h0020);
        rdChk(`NVC_IDX_STAT, 16'h0000);
    endtask

    // Refused command: no launch, done and fail both raised
    task automatic refuse(input logic [15:0] ctrl);
        int n0;
        n0 = startCount;
        wr(`NVC_IDX_CTRL, ctrl);
        idle(3);
        check(startCount, n0, "no start");
        rdChk(`NVC_IDX_STAT, 16'h0030);
        wr(`NVC_IDX_STAT, 16'h0030);
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial
    begin
        reset_n = 1'b0;
        wbCyc = 1'b0;
        wbStb = 1'b0;
        wbWe = 1'b0;
        wbAdr = '0;
        wbSel = 4'h0;
        wbDatI = '0;
        memResult = '0;
        bad_count = 0;
        check_count = 0;
        idle(16);
        reset_n <= 1'b1;
        check(progState, 1'b0, "prog at reset");
        check(memIrq, 1'b0, "irq at reset");
        rdChk(`NVC_IDX_CTRL, 16'h2000);
        rdChk(`NVC_IDX_STAT, 16'h0000);
        rdChk(`NVC_IDX_MASK, 16'h0030);
        rdChk(16'h4000, 16'h0000);
        $display("test reset values done");

        // Locked: protected fields keep their values
        wr(`NVC_IDX_CTRL, 16'h8000);
        rdChk(`NVC_IDX_CTRL, 16'h2000);
        check(progState, 1'b0, "locked prog");
        wr(`NVC_IDX_KEY, `NVC_UNLOCK_CODE);
        rdChk(`NVC_IDX_KEY, 16'h0001);
        wr(`NVC_IDX_CTRL, 16'h2100);
        idle(3);
        check(startCount, 0, "no start before prog");
        wr(`NVC_IDX_CTRL, 16'h0000);
        check(progState, 1'b0, "zero is no action");
        wr(`NVC_IDX_CTRL, 16'ha000);
        check(progState, 1'b1, "prog entered");
        wr(`NVC_IDX_CTRL, 16'h2000);
        rdChk(`NVC_IDX_CTRL, 16'ha000);
        check(progState, 1'b1, "prog held");
        $display("test key and program state done");

        // Commands keep the program bit and unused bits at zero
        runCmd(16'h2100, mk(NVC_OP_READ, 1'b1, 1'b0, 3'h0, 2'h0));
        runCmd(16'h2103, mk(NVC_OP_READ, 1'b1, 1'b0, 3'h3, 2'h0));
        runCmd(16'h2480, mk(NVC_OP_VERIFY, 1'b1, 1'b0, 3'h0, 2'h2));
        runCmd(16'h24c1, mk(NVC_OP_VERIFY, 1'b1, 1'b0, 3'h1, 2'h3));
        runCmd(16'h24a0, mk(NVC_OP_VERIFY, 1'b1, 1'b1, 3'h0, 2'h2));
        runCmd(16'h2202, mk(NVC_OP_WRITE, 1'b1, 1'b0, 3'h2, 2'h0));
        runCmd(16'h0100, mk(NVC_OP_READ, 1'b0, 1'b0, 3'h2, 2'h0));
        runCmd(16'h0101, mk(NVC_OP_READ, 1'b0, 1'b0, 3'h3, 2'h0));
        runCmd(16'h0102, mk(NVC_OP_READ, 1'b0, 1'b0, 3'h4, 2'h0));
        runCmd(16'h0120, mk(NVC_OP_READ, 1'b0, 1'b1, 3'h2, 2'h0));
        refuse(16'h0103);
        refuse(16'h2140);
        refuse(16'h0200);
        $display("test command table done");

        // Second command while busy is dropped
        wr(`NVC_IDX_CTRL, 16'h2100);
        wr(`NVC_IDX_CTRL, 16'h2101);
        idle(2);
        check(startCount, 11, "busy drop");
        check({23'h0, lastCmd}, {23'h0, mk(NVC_OP_READ, 1'b1, 1'b0,
              3'h0, 2'h0)}, "busy cmd");
        pulse('{done: 1'b1, default: 1'b0});
        wr(`NVC_IDX_STAT, 16'h0020);
        runCmd(16'h2802, mk(NVC_OP_FINAL, 1'b1, 1'b0, 3'h2, 2'h0));
        refuse(16'h2202);
        $display("test busy and finalise done");

        // Flags, masks and interrupt
        pulse('{autoProgDone: 1'b1, default: 1'b0});
        rdChk(`NVC_IDX_STAT, 16'h0020);
        check(memIrq, 1'b0, "masked");
        wr(`NVC_IDX_MASK, 16'h0010);
        check(memIrq, 1'b1, "done unmasked");
        pulse('{verifyFail: 1'b1, default: 1'b0});
        rdChk(`NVC_IDX_STAT, 16'h0030);
        wr(`NVC_IDX_STAT, 16'h0020);
        check(memIrq, 1'b0, "fail masked");
        wr(`NVC_IDX_MASK, 16'h0020);
        check(memIrq, 1'b1, "fail unmasked");
        wr(`NVC_IDX_STAT, 16'h0010);
        check(memIrq, 1'b0, "cleared");
        // A held event level sets the flag once only
        memResult <= '{readFail: 1'b1, default: 1'b0};
        idle(2);
        rdChk(`NVC_IDX_STAT, 16'h0010);
        wr(`NVC_IDX_STAT, 16'h0010);
        idle(2);
        rdChk(`NVC_IDX_STAT, 16'h0000);
        memResult <= '0;
        $display("test flags and interrupt done");

        // Relocking blocks new commands
        wr(`NVC_IDX_KEY, 16'h0000);
        wr(`NVC_IDX_CTRL, 16'h2100);
        idle(3);
        check(startCount, 12, "relocked");
        $display("test relock done");

        // Only a reset leaves programming state
        reset_n <= 1'b0;
        idle(2);
        reset_n <= 1'b1;
        check(progState, 1'b0, "prog after reset");
        rdChk(`NVC_IDX_CTRL, 16'h2000);
        rdChk(`NVC_IDX_MASK, 16'h0030);
        $display("test reset in run done");
        summarize();
    end
endmodule
